// ---- logic/spr_consts.svh ----
// Constants for one port of the synchronous pipelined dual-port RAM.
// Assumes inclusion by the package and by the design modules only.
`ifndef SPR_CONSTS_SVH
`define SPR_CONSTS_SVH

// Array geometry.
`define SPR_ADDR_W      16
`define SPR_DATA_W      18
`define SPR_BYTE_W      9
`define SPR_DEPTH       65536
`define SPR_BYTES       2
`define SPR_UPPER_BYTE  1
`define SPR_LOWER_BYTE  0

// Reset values of the port registers, with the counter clear value and step.
`define SPR_ADDR_RST    16'h0000
`define SPR_ADDR_ZERO   16'h0000
`define SPR_ADDR_STEP   16'h0001
`define SPR_DATA_RST    18'h00000
`define SPR_BYTE_RST    2'h0
`define SPR_BYTE_OFF    2'h3

`endif

// ---- logic/spr_pkg.sv ----
// Types shared by the RAM port and its array.
// Assumes the constants header is on the include path.
`include "spr_consts.svh"

package spr_pkg;
    typedef logic [`SPR_ADDR_W-1:0]  spr_addr_t;
    typedef logic [`SPR_DATA_W-1:0]  spr_word_t;
    typedef logic [`SPR_BYTES-1:0]   spr_bytes_t;

    // Power state of the port, one-hot.
    typedef enum logic [2:0] {
        SPR_PWR_DOWN = 3'h1,
        SPR_PWR_WAKE = 3'h2,
        SPR_PWR_ON   = 3'h4
    } spr_pwr_t;
endpackage

// ---- logic/spr_mem_if.sv ----
// Connection between the port logic and the storage array.
// Assumes both ends share one clock.
interface spr_mem_if;
    spr_pkg::spr_bytes_t wr_en;      // Byte write strobes of this port.
    spr_pkg::spr_addr_t  wr_addr;    // Write address of this port.
    spr_pkg::spr_word_t  wr_data;    // Write data of this port.
    logic                far_en;     // Word write from the opposite port.
    spr_pkg::spr_addr_t  far_addr;   // Opposite port write address.
    spr_pkg::spr_word_t  far_data;   // Opposite port write data.
    spr_pkg::spr_addr_t  rd_addr;    // Read address.
    spr_pkg::spr_word_t  rd_data;    // Registered read data.

    modport ctl (output wr_en, wr_addr, wr_data, far_en, far_addr,
                 far_data, rd_addr, input rd_data);
    modport mem (input wr_en, wr_addr, wr_data, far_en, far_addr,
                 far_data, rd_addr, output rd_data);
endinterface

// ---- logic/spr_array.sv ----
// Storage array with byte writes, opposite-port word writes and a
// registered read. Assumes one clock for all requests.
`include "spr_consts.svh"

module spr_array (
    input  wire logic clk,         // Port clock.
    spr_mem_if.mem    mem          // Requests from the port logic.
);
    // ------------------------------------------------------------
    // Array
    // ------------------------------------------------------------
    // Whole-word store of 18-bit words in two 9-bit bytes.
    spr_pkg::spr_word_t store [`SPR_DEPTH];
    spr_pkg::spr_word_t rd_reg;

    // Writes complete within the cycle that follows sampling; the
    // opposite port is applied last so it wins a same-word clash.
    always_ff @(posedge clk) begin
        if (mem.wr_en[`SPR_LOWER_BYTE]) begin
            store[mem.wr_addr][`SPR_BYTE_W-1:0] <=
                mem.wr_data[`SPR_BYTE_W-1:0];
        end
        if (mem.wr_en[`SPR_UPPER_BYTE]) begin
            store[mem.wr_addr][`SPR_DATA_W-1:`SPR_BYTE_W] <=
                mem.wr_data[`SPR_DATA_W-1:`SPR_BYTE_W];
        end
        if (mem.far_en) begin
            store[mem.far_addr] <= mem.far_data;
        end
        rd_reg <= store[mem.rd_addr];
    end

    assign mem.rd_data = rd_reg;
endmodule

// ---- logic/spr_port.sv ----
// One port of a synchronous pipelined dual-port static RAM.
// Assumes a host on the same clock; the data pins are resolved outside.
`include "spr_consts.svh"

module spr_port (
    input  wire logic               clk,                     // Clock.
    input  wire logic               sys_rst,                 // Sync reset.
    input  wire spr_pkg::spr_addr_t address_in,              // Address.
    input  wire spr_pkg::spr_word_t data_in,                 // Write data.
    input  wire logic               read_write,              // 1 read.
    input  wire logic               chip_select_low_active,  // Select, low.
    input  wire logic               chip_select_high_active, // Select, high.
    input  wire logic               upper_byte_enable_n,     // Upper byte.
    input  wire logic               lower_byte_enable_n,     // Lower byte.
    input  wire logic               address_strobe_n,        // Load address.
    input  wire logic               counter_advance_n,       // Count up.
    input  wire logic               counter_clear_n,         // Clear count.
    input  wire logic               output_enable_n,         // Async enable.
    input  wire logic               far_write_en,            // Far write.
    input  wire spr_pkg::spr_addr_t far_write_addr,          // Far address.
    input  wire spr_pkg::spr_word_t far_write_data,          // Far data.
    input  wire logic               far_offset_ok,           // Offset met.
    output wire spr_pkg::spr_word_t data_out,                // Read data.
    output wire spr_pkg::spr_bytes_t data_oe_n               // Drive, low.
);
    // ------------------------------------------------------------
    // Sampled controls
    // ------------------------------------------------------------
    logic                selected;
    spr_pkg::spr_bytes_t be_n;

    // Decoded chip select and byte enables of the current cycle.
    assign selected = !chip_select_low_active && chip_select_high_active;
    assign be_n     = {upper_byte_enable_n, lower_byte_enable_n};

    spr_pkg::spr_addr_t  addr_reg,  addr_next;
    spr_pkg::spr_word_t  wdata_reg, wdata_next;
    spr_pkg::spr_bytes_t we_reg,    we_next;
    logic                rd1_reg,   rd1_next;
    spr_pkg::spr_bytes_t be1_reg,   be1_next;

    // Address counter and first pipeline stage. The address register is
    // the burst counter, so clear beats load beats advance beats hold.
    always_comb begin
        if (!counter_clear_n) begin
            addr_next = `SPR_ADDR_ZERO;
        end else if (!address_strobe_n) begin
            addr_next = address_in;
        end else if (!counter_advance_n) begin
            addr_next = addr_reg + `SPR_ADDR_STEP;
        end else begin
            addr_next = addr_reg;
        end
        wdata_next = data_in;
        we_next    = {`SPR_BYTES{selected && !read_write}} & ~be_n;
        rd1_next   = selected && read_write;
        be1_next   = be_n;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            addr_reg  <= `SPR_ADDR_RST;
            wdata_reg <= `SPR_DATA_RST;
            we_reg    <= `SPR_BYTE_RST;
            rd1_reg   <= 1'b0;
            be1_reg   <= `SPR_BYTE_OFF;
        end else begin
            addr_reg  <= addr_next;
            wdata_reg <= wdata_next;
            we_reg    <= we_next;
            rd1_reg   <= rd1_next;
            be1_reg   <= be1_next;
        end
    end

    // ------------------------------------------------------------
    // Power state
    // ------------------------------------------------------------
    spr_pkg::spr_pwr_t pwr_reg, pwr_next;

    // Any deselected cycle powers down; two selected cycles wake up.
    always_comb begin
        pwr_next = pwr_reg;
        if (!selected) begin
            pwr_next = spr_pkg::SPR_PWR_DOWN;
        end else begin
            case (pwr_reg)
                spr_pkg::SPR_PWR_DOWN: pwr_next = spr_pkg::SPR_PWR_WAKE;
                spr_pkg::SPR_PWR_WAKE: pwr_next = spr_pkg::SPR_PWR_ON;
                default:               pwr_next = spr_pkg::SPR_PWR_ON;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pwr_reg <= spr_pkg::SPR_PWR_DOWN;
        end else begin
            pwr_reg <= pwr_next;
        end
    end

    // ------------------------------------------------------------
    // Opposite-port writes
    // ------------------------------------------------------------
    logic               fen_reg,   fen_next;
    logic               fok_reg,   fok_next;
    spr_pkg::spr_addr_t faddr_reg, faddr_next;
    spr_pkg::spr_word_t fdata_reg, fdata_next;
    logic               pen_reg,   pen_next;
    spr_pkg::spr_addr_t paddr_reg, paddr_next;
    spr_pkg::spr_word_t pdata_reg, pdata_next;

    // A write that arrives too close to our edge is held one extra
    // cycle; once a write is pending, later ones queue behind it.
    always_comb begin
        fen_next   = far_write_en;
        fok_next   = far_offset_ok;
        faddr_next = far_write_addr;
        fdata_next = far_write_data;
        pen_next   = fen_reg && (!fok_reg || pen_reg);
        paddr_next = faddr_reg;
        pdata_next = fdata_reg;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fen_reg   <= 1'b0;
            fok_reg   <= 1'b0;
            faddr_reg <= `SPR_ADDR_RST;
            fdata_reg <= `SPR_DATA_RST;
            pen_reg   <= 1'b0;
            paddr_reg <= `SPR_ADDR_RST;
            pdata_reg <= `SPR_DATA_RST;
        end else begin
            fen_reg   <= fen_next;
            fok_reg   <= fok_next;
            faddr_reg <= faddr_next;
            fdata_reg <= fdata_next;
            pen_reg   <= pen_next;
            paddr_reg <= paddr_next;
            pdata_reg <= pdata_next;
        end
    end

    // ------------------------------------------------------------
    // Array and output stage
    // ------------------------------------------------------------
    spr_mem_if mem_bus ();

    // Drive the array from the first stage and the far-write path.
    assign mem_bus.wr_en    = we_reg;
    assign mem_bus.wr_addr  = addr_reg;
    assign mem_bus.wr_data  = wdata_reg;
    assign mem_bus.rd_addr  = addr_reg;
    assign mem_bus.far_en   = pen_reg || (fen_reg && fok_reg);
    assign mem_bus.far_addr = pen_reg ? paddr_reg : faddr_reg;
    assign mem_bus.far_data = pen_reg ? pdata_reg : fdata_reg;

    spr_array u_array (
        .clk (clk),
        .mem (mem_bus)
    );

    logic                rd2_reg, rd2_next;
    spr_pkg::spr_bytes_t be2_reg, be2_next;
    spr_pkg::spr_word_t  dout_reg, dout_next;
    spr_pkg::spr_bytes_t drv_reg, drv_next;
    logic                out_ok;

    // Output is allowed only while powered and some byte is enabled.
    assign out_ok = (pwr_next == spr_pkg::SPR_PWR_ON) && !(&be_n);

    // Second stage carries the read, third registers data and drive.
    always_comb begin
        rd2_next  = rd1_reg;
        be2_next  = be1_reg;
        dout_next = mem_bus.rd_data;
        drv_next  = {`SPR_BYTES{rd2_reg && out_ok}} & ~be2_reg;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd2_reg  <= 1'b0;
            be2_reg  <= `SPR_BYTE_OFF;
            dout_reg <= `SPR_DATA_RST;
            drv_reg  <= `SPR_BYTE_RST;
        end else begin
            rd2_reg  <= rd2_next;
            be2_reg  <= be2_next;
            dout_reg <= dout_next;
            drv_reg  <= drv_next;
        end
    end

    // Output enable acts without the clock on the pin drivers.
    assign data_out  = dout_reg;
    assign data_oe_n = ~drv_reg | {`SPR_BYTES{output_enable_n}};

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_two_selected;
        (pwr_reg == spr_pkg::SPR_PWR_DOWN && selected) ##1 selected;
    endsequence

    sequence s_lower_read;
        (pwr_reg == spr_pkg::SPR_PWR_ON && selected && read_write &&
         !lower_byte_enable_n) ##1 selected ##1 (selected && !(&be_n));
    endsequence

    property p_clear;
        !counter_clear_n |=> addr_reg == `SPR_ADDR_ZERO;
    endproperty
    a_clear: assert property (p_clear)
        else $error("Counter clear did not zero the address.");
    property p_load;
        counter_clear_n && !address_strobe_n |=>
            addr_reg == $past(address_in);
    endproperty
    a_load: assert property (p_load)
        else $error("Address strobe did not load the address.");
    property p_advance;
        counter_clear_n && address_strobe_n && !counter_advance_n |=>
            addr_reg == spr_pkg::spr_addr_t'($past(addr_reg) + 1'b1);
    endproperty
    a_advance: assert property (p_advance)
        else $error("Counter advance did not step the address.");
    property p_hold;
        counter_clear_n && address_strobe_n && counter_advance_n |=>
            $stable(addr_reg);
    endproperty
    a_hold: assert property (p_hold)
        else $error("Stalled counter changed the address.");
    property p_down;
        !selected |=> pwr_reg == spr_pkg::SPR_PWR_DOWN && drv_reg == 2'h0;
    endproperty
    a_down: assert property (p_down)
        else $error("Deselect did not power down the port.");
    property p_wake;
        s_two_selected |=> pwr_reg == spr_pkg::SPR_PWR_ON;
    endproperty
    a_wake: assert property (p_wake)
        else $error("Port did not wake after two selected cycles.");
    property p_no_early;
        pwr_reg == spr_pkg::SPR_PWR_DOWN |=> pwr_reg != spr_pkg::SPR_PWR_ON;
    endproperty
    a_no_early: assert property (p_no_early)
        else $error("Port woke after a single selected cycle.");
    property p_off;
        (!selected || &be_n) |=> &data_oe_n;
    endproperty
    a_off: assert property (p_off)
        else $error("Outputs driven after deselect or both bytes off.");
    property p_latency;
        s_lower_read |=> drv_reg[`SPR_LOWER_BYTE] &&
            data_out == $past(mem_bus.rd_data);
    endproperty
    a_latency: assert property (p_latency)
        else $error("Read data not driven two cycles after the request.");
    property p_byte_off;
        (selected && read_write && lower_byte_enable_n) ##2 1'b1 |=>
            !drv_reg[`SPR_LOWER_BYTE];
    endproperty
    a_byte_off: assert property (p_byte_off)
        else $error("Disabled byte was driven.");
    property p_oe;
        output_enable_n |-> &data_oe_n;
    endproperty
    a_oe: assert property (p_oe)
        else $error("Output enable high but pins driven.");
    property p_far;
        far_write_en && !far_offset_ok |=> ##1 pen_reg;
    endproperty
    a_far: assert property (p_far)
        else $error("Late opposite-port write was not held back.");
endmodule

// ---- tb/spr_far_model.sv ----
// Behavioural model of the opposite port, which writes whole words.
// Assumes commands arrive by non-blocking update at the falling edge.
module spr_far_model (
    input  wire logic               clk,            // Port clock.
    input  wire logic               cmd_en,         // Issue one write.
    input  wire spr_pkg::spr_addr_t cmd_addr,       // Address to write.
    input  wire spr_pkg::spr_word_t cmd_data,       // Word to write.
    input  wire logic               cmd_ok,         // Offset is met.
    output spr_pkg::spr_addr_t      far_write_addr, // Far address.
    output spr_pkg::spr_word_t      far_write_data, // Far data.
    output logic                    far_write_en,   // Far write.
    output logic                    far_offset_ok   // Offset flag.
);
    timeunit 1ns;
    timeprecision 1ps;

    // Start idle so that no stray write reaches the array.
    initial begin
        far_write_en = 1'b0;
        far_write_addr = 16'h0000;
        far_write_data = 18'h00000;
        far_offset_ok = 1'b1;
    end

    // Drive one write per command; idle lines toggle so that stale
    // values are never mistaken for a held request.
    always @(negedge clk) begin
        if (cmd_en) begin
            far_write_en <= 1'b1;
            far_write_addr <= cmd_addr;
            far_write_data <= cmd_data;
            far_offset_ok <= cmd_ok;
        end else begin
            far_write_en <= 1'b0;
            far_write_addr <= ~far_write_addr;
            far_write_data <= ~far_write_data;
            far_offset_ok <= ~far_offset_ok;
        end
    end
endmodule

// ---- tb/sync_pipelined_dual_port_ram_port_tb.sv ----
// Self-checking bench for one RAM port: reads, bursts, power, far writes.
// Assumes the design files and the far-port model are compiled first.
module sync_pipelined_dual_port_ram_port_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    localparam logic [2:0] LD = 3'h3;
    localparam logic [2:0] ADV = 3'h5;
    localparam logic [2:0] HOLD = 3'h7;
    localparam logic [2:0] CLR = 3'h6;
    logic                clk;
    logic                sys_rst;
    spr_pkg::spr_addr_t  address_in;
    spr_pkg::spr_word_t  data_in;
    logic                read_write;
    logic                sel_n;
    logic                sel;
    logic                ube_n;
    logic                lbe_n;
    logic                strobe_n;
    logic                adv_n;
    logic                clr_n;
    logic                output_enable_n;
    logic                fw_en;
    logic                fw_ok;
    spr_pkg::spr_addr_t  fw_addr;
    spr_pkg::spr_word_t  fw_data;
    logic                fc_en;
    logic                fc_ok;
    spr_pkg::spr_addr_t  fc_addr;
    spr_pkg::spr_word_t  fc_data;
    spr_pkg::spr_word_t  data_out;
    spr_pkg::spr_bytes_t data_oe_n;
    int                  fail_count;
    int                  cmp_count;

    // Clock at 250 MHz.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    spr_port dut (.clk(clk), .sys_rst(sys_rst), .address_in(address_in),
        .data_in(data_in), .read_write(read_write),
        .chip_select_low_active(sel_n), .chip_select_high_active(sel),
        .upper_byte_enable_n(ube_n), .lower_byte_enable_n(lbe_n),
        .address_strobe_n(strobe_n), .counter_advance_n(adv_n),
        .counter_clear_n(clr_n), .output_enable_n(output_enable_n),
        .far_write_en(fw_en), .far_write_addr(fw_addr),
        .far_write_data(fw_data), .far_offset_ok(fw_ok),
        .data_out(data_out), .data_oe_n(data_oe_n));

    spr_far_model far (.clk(clk), .cmd_en(fc_en), .cmd_addr(fc_addr),
        .cmd_data(fc_data), .cmd_ok(fc_ok), .far_write_addr(fw_addr),
        .far_write_data(fw_data), .far_write_en(fw_en),
        .far_offset_ok(fw_ok));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Compares a seen value with the expected one.
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask

    // Presents one cycle of host inputs at the falling edge.
    task automatic tick(input logic rw, input spr_pkg::spr_addr_t a,
                        input spr_pkg::spr_word_t d,
                        input spr_pkg::spr_bytes_t be, input logic [2:0] c);
        read_write = rw;
        address_in = a;
        data_in = d;
        // Byte and counter controls move as one group, as when ganged.
        {ube_n, lbe_n} = be;
        {strobe_n, adv_n, clr_n} = c;
        @(negedge clk);
    endtask

    // Reads one word with a loaded address and checks it two edges on.
    task automatic rd(input spr_pkg::spr_addr_t a,
                      input spr_pkg::spr_word_t exp);
        tick(1'b1, a, 18'h00000, 2'h0, LD);
        tick(1'b1, a, 18'h00000, 2'h0, LD);
        tick(1'b1, a, 18'h00000, 2'h0, LD);
        chk(data_out, exp);
        chk({16'h0000, data_oe_n}, 18'h00000);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Back-to-back writes and reads at the top address and at 0001, then byte accesses at 0001.
    task automatic t_rw();
        tick(1'b0, 16'hffff, 18'h2a5a5, 2'h0, LD);
        tick(1'b0, 16'h0001, 18'h15a5a, 2'h0, LD);
        rd(16'hffff, 18'h2a5a5);
        rd(16'h0001, 18'h15a5a);
        // Idle turnaround, then the host rewrites the upper byte of the word just read.
        tick(1'b1, 16'h0001, 18'h00000, 2'h3, LD);
        chk({16'h0000, data_oe_n}, 18'h00003);
        tick(1'b0, 16'h0001, 18'h3fe01, 2'h1, LD);
        rd(16'h0001, 18'h3fe5a);
        tick(1'b1, 16'h0001, 18'h00000, 2'h2, LD);
        tick(1'b1, 16'h0001, 18'h00000, 2'h0, LD);
        tick(1'b1, 16'h0001, 18'h00000, 2'h0, LD);
        chk({16'h0000, data_oe_n}, 18'h00002);
        chk({9'h000, data_out[8:0]}, 18'h0005a);
        tick(1'b1, 16'h0001, 18'h00000, 2'h3, LD);
        chk({16'h0000, data_oe_n}, 18'h00003);
    endtask

    // Burst write, then burst read with advance and hold.
    task automatic t_burst();
        tick(1'b0, 16'h0100, 18'h00011, 2'h0, LD);
        tick(1'b0, 16'hbeef, 18'h00022, 2'h0, ADV);
        tick(1'b0, 16'hbeef, 18'h00033, 2'h0, ADV);
        rd(16'h0101, 18'h00022);
        rd(16'h0102, 18'h00033);
        tick(1'b1, 16'h0100, 18'h00000, 2'h0, LD);
        tick(1'b1, 16'hffff, 18'h00000, 2'h0, ADV);
        tick(1'b1, 16'hffff, 18'h00000, 2'h0, HOLD);
        chk(data_out, 18'h00011);
        for (int i = 0; i < 3; i++) begin
            tick(1'b1, 16'hffff, 18'h00000, 2'h0, HOLD);
            chk(data_out, 18'h00022);
        end
    endtask

    // Counter clear sends a write and a read to address zero.
    task automatic t_clear();
        tick(1'b0, 16'h0777, 18'h1c3c3, 2'h0, CLR);
        rd(16'h0000, 18'h1c3c3);
        tick(1'b1, 16'h0555, 18'h00000, 2'h0, CLR);
        tick(1'b1, 16'h0555, 18'h00000, 2'h0, HOLD);
        tick(1'b1, 16'h0555, 18'h00000, 2'h0, HOLD);
        chk(data_out, 18'h1c3c3);
    endtask

    // Each deselect kind powers down; two selected edges wake it.
    task automatic t_power();
        for (int i = 0; i < 2; i++) begin
            sel_n = (i == 0);
            sel = (i == 0);
            tick(1'b1, 16'hffff, 18'h00000, 2'h0, LD);
            chk({16'h0000, data_oe_n}, 18'h00003);
            sel_n = 1'b0;
            sel = 1'b1;
            tick(1'b1, 16'hffff, 18'h00000, 2'h0, LD);
            chk({16'h0000, data_oe_n}, 18'h00003);
            tick(1'b1, 16'hffff, 18'h00000, 2'h0, LD);
            tick(1'b1, 16'hffff, 18'h00000, 2'h0, LD);
            chk(data_out, 18'h2a5a5);
            chk({16'h0000, data_oe_n}, 18'h00000);
        end
    endtask

    // Output enable gates the drivers between clock edges.
    task automatic t_oe();
        output_enable_n = 1'b1;
        #1;
        chk({16'h0000, data_oe_n}, 18'h00003);
        output_enable_n = 1'b0;
        #0.5;
        chk({16'h0000, data_oe_n}, 18'h00000);
        // Realign to the falling edge before the next stimulus.
        @(negedge clk);
    endtask

    // Opposite-port write seen one read later when the offset is short.
    task automatic t_far(input logic ok, input spr_pkg::spr_addr_t a,
                         input spr_pkg::spr_word_t v);
        spr_pkg::spr_word_t q [6];
        tick(1'b0, a, ~v, 2'h0, LD);
        fc_en <= 1'b1;
        fc_addr <= a;
        fc_data <= v;
        fc_ok <= ok;
        for (int i = 0; i < 6; i++) begin
            tick(1'b1, a, 18'h00000, 2'h0, LD);
            fc_en <= 1'b0;
            q[i] = data_out;
        end
        chk(q[3], ~v);
        chk(q[4], ok ? v : ~v);
        chk(q[5], v);
    endtask

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        fail_count = 0;
        cmp_count = 0;
        sys_rst = 1'b1;
        sel_n = 1'b0;
        sel = 1'b1;
        output_enable_n = 1'b0;
        fc_en = 1'b0;
        fc_ok = 1'b1;
        fc_addr = 16'h0000;
        fc_data = 18'h00000;
        read_write = 1'b1;
        address_in = 16'h0000;
        data_in = 18'h00000;
        {ube_n, lbe_n} = 2'h0;
        {strobe_n, adv_n, clr_n} = HOLD;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        chk({16'h0000, data_oe_n}, 18'h00003);
        chk(data_out, 18'h00000);
        tick(1'b1, 16'h0000, 18'h00000, 2'h0, LD);
        tick(1'b1, 16'h0000, 18'h00000, 2'h0, LD);
        t_rw();
        t_burst();
        t_clear();
        t_power();
        t_oe();
        t_far(1'b1, 16'h0200, 18'h12345);
        t_far(1'b0, 16'h0300, 18'h0abcd);
        stop_test();
    end

    // Cuts a hang short well after the 66 or so cycles needed.
    initial begin
        #5000;
        fail_count++;
        stop_test();
    end
endmodule
